// ---- inc/sfcm_pkg.sv ----
// Package: constants for the serial frame check and write-multiple responder
package sfcm_pkg;
    localparam logic [7:0] SFCM_FUNC_WRITE_MULTI = 8'h10;
    localparam logic [15:0] SFCM_CRC_INIT = 16'hFFFF;
    localparam logic [15:0] SFCM_CRC_POLY = 16'hA001;
    localparam int SFCM_BITS_PER_BYTE = 8;
    localparam int SFCM_HDR_BYTES = 7;
    localparam int SFCM_REPLY_BYTES = 6;
    localparam int SFCM_CLK_MHZ = 200;
    localparam int SFCM_SILENCE_MS = 10;
    localparam int SFCM_SILENCE_CYCLES = SFCM_SILENCE_MS * 1000 * SFCM_CLK_MHZ + 1;
    localparam int SFCM_FIFO_DEPTH = 4;
    localparam logic [7:0] SFCM_ASCII_ZERO = 8'h30;
    localparam logic [7:0] SFCM_ASCII_A_MINUS_10 = 8'h37;
    localparam logic [7:0] SFCM_ASCII_COLON = 8'h3A;
    localparam logic [7:0] SFCM_ASCII_CR = 8'h0D;
    localparam logic [7:0] SFCM_ASCII_LF = 8'h0A;
endpackage

// ---- logic/sfcm_fifo.sv ----
// Small valid/ready FIFO carrying received frame bytes
`timescale 1ns/1ps
module sfcm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            if (do_rd)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wr_ptr] <= in_data;
    end
endmodule // sfcm_fifo

// ---- logic/sfcm_top.sv ----
// Write-multiple frame checker and responder with LRC and bit-serial CRC
`timescale 1ns/1ps
module sfcm_top
    import sfcm_pkg::*;
#(
    parameter int SILENCE_CYCLES = sfcm_pkg::SFCM_SILENCE_CYCLES,
    parameter logic [7:0] STATION = 8'h01
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic ASCII_MODE,
    input wire logic RX_VALID,
    output logic RX_READY,
    input wire logic [7:0] RX_BYTE,
    input wire logic RX_END,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [7:0] TX_BYTE,
    output logic FRAME_OK,
    output logic FRAME_BAD,
    output logic [15:0] WORD_DATA,
    output logic [15:0] WORD_ADDR,
    output logic WORD_STROBE
);
    import sfcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input FIFO; bit 8 marks an explicit end of frame (ASCII LF seen upstream)
    logic f_valid;
    logic f_ready;
    logic [8:0] f_data;
    sfcm_fifo #(.WIDTH(9), .DEPTH(SFCM_FIFO_DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .in_valid(RX_VALID),
        .in_ready(RX_READY),
        .in_data({RX_END, RX_BYTE}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    typedef enum {S_IDLE, S_RX, S_CRC, S_CHECK, S_TX_BYTE} sfcm_state_e;
    sfcm_state_e state;
    sfcm_state_e next_state;

    logic [15:0] crc;
    logic [7:0] lrc;
    logic [2:0] bit_cnt;
    logic [7:0] byte_idx;
    logic [7:0] hdr [SFCM_HDR_BYTES];
    logic [7:0] data_hi;
    logic [15:0] word_cnt;
    logic [31:0] idle_cnt;
    logic rx_done;
    logic [2:0] tx_idx;
    logic [1:0] tx_phase;
    logic [7:0] tx_cur;

    ////////////////////////////////////////////////////////////////////////////
    // Byte intake: in RTU mode CRC runs over every byte, so check bytes included;
    // a good frame then leaves the register at zero, avoiding a two-byte lookback.
    wire take = (state == S_RX || state == S_IDLE) && f_valid;
    assign f_ready = (state == S_RX || state == S_IDLE);
    wire [7:0] in_b = f_data[7:0];
    wire in_end = f_data[8];
    wire silence = (idle_cnt >= 32'(SILENCE_CYCLES)) && (state == S_RX) && !ASCII_MODE;
    wire ascii_end = take && in_end && ASCII_MODE;

    // One CRC bit step
    wire crc_lsb = crc[0];
    wire [15:0] crc_shift = {1'b0, crc[15:1]};
    wire [15:0] crc_step = crc_lsb ? (crc_shift ^ SFCM_CRC_POLY) : crc_shift;

    // Frame field checks; in ASCII mode the last byte is the LRC itself
    wire [15:0] req_words = {hdr[4], hdr[5]};
    wire hdr_ok = (hdr[0] == STATION) && (hdr[1] == SFCM_FUNC_WRITE_MULTI);
    wire cnt_ok = ({8'h00, hdr[6]} == {req_words[14:0], 1'b0}) && (req_words[15] == 1'b0);
    wire [7:0] total_exp = 8'(SFCM_HDR_BYTES) + hdr[6] + (ASCII_MODE ? 8'd1 : 8'd2);
    wire len_ok = (byte_idx == total_exp);
    wire chk_ok = ASCII_MODE ? (lrc == 8'h00) : (crc == 16'h0000);
    wire frame_good = hdr_ok && cnt_ok && len_ok && chk_ok;

    // Reply bytes: echo of the first six header bytes
    wire [7:0] reply_b = hdr[tx_idx];
    wire [15:0] crc_b = crc;
    wire [7:0] lrc_b = 8'(-lrc);

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state = state;
        unique case (state)
            // In RTU the first byte needs its eight shifts like every other byte
            S_IDLE: if (take) next_state = ASCII_MODE ? S_RX : S_CRC;
            S_RX:
            begin
                if (take && !ASCII_MODE)
                    next_state = S_CRC;
                else if (ascii_end || silence)
                    next_state = S_CHECK;
            end
            S_CRC: if (bit_cnt == 3'(SFCM_BITS_PER_BYTE - 1)) next_state = rx_done ? S_CHECK : S_RX;
            S_CHECK: next_state = frame_good ? S_TX_BYTE : S_IDLE;
            S_TX_BYTE:
            begin
                // Leave on acceptance of the last character so that it goes out once only
                if (TX_READY && (ASCII_MODE ? (tx_phase == 2'h3) : (tx_idx == 3'(SFCM_REPLY_BYTES + 1))))
                    next_state = S_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit: tx_phase steps through the parts; ASCII sends :, hex pairs, CR, LF.
    // RTU sends six echo bytes then CRC low, high. Modelled as one stream index.
    logic [7:0] tx_byte_now;
    logic tx_last_item;
    wire [3:0] tx_items = ASCII_MODE ? 4'(SFCM_REPLY_BYTES + 1) : 4'(SFCM_REPLY_BYTES + 2);
    logic [3:0] tx_item;
    logic tx_hex_lo;
    always_comb
    begin
        tx_byte_now = 8'h00;
        if (tx_item < 4'(SFCM_REPLY_BYTES))
            tx_byte_now = reply_b;
        else if (ASCII_MODE)
            tx_byte_now = lrc_b;
        else if (tx_item == 4'(SFCM_REPLY_BYTES))
            tx_byte_now = crc_b[7:0];
        else
            tx_byte_now = crc_b[15:8];
    end
    assign tx_last_item = (tx_item == tx_items - 4'd1);
    assign TX_VALID = (state == S_TX_BYTE);

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            crc <= SFCM_CRC_INIT;
            lrc <= 8'h00;
            bit_cnt <= 3'd0;
            byte_idx <= 8'h00;
            idle_cnt <= 32'd0;
            rx_done <= 1'b0;
            data_hi <= 8'h00;
            word_cnt <= 16'h0000;
            for (int i = 0; i < SFCM_HDR_BYTES; i++)
                hdr[i] <= 8'h00;
        end
        else
        begin
            idle_cnt <= take ? 32'd0 : ((idle_cnt < 32'(SILENCE_CYCLES)) ? idle_cnt + 32'd1 : idle_cnt);
            if (state == S_IDLE && take)
            begin
                crc <= SFCM_CRC_INIT ^ {8'h00, in_b};
                lrc <= in_b;
                byte_idx <= 8'h01;
                hdr[0] <= in_b;
                bit_cnt <= 3'd0;
                rx_done <= 1'b0;
                word_cnt <= 16'h0000;
            end
            else if (state == S_RX && take)
            begin
                crc <= crc ^ {8'h00, in_b};
                lrc <= lrc + in_b;
                byte_idx <= byte_idx + 8'h01;
                if (byte_idx < 8'(SFCM_HDR_BYTES))
                    hdr[byte_idx[2:0]] <= in_b;
                // Data starts at an odd index, so odd bytes are high halves
                else if (byte_idx[0])
                    data_hi <= in_b;
                else
                    word_cnt <= word_cnt + 16'h0001;
            end
            else if (state == S_IDLE && !ASCII_MODE)
                crc <= SFCM_CRC_INIT;
            if (state == S_CRC)
            begin
                crc <= crc_step;
                bit_cnt <= bit_cnt + 3'd1;
            end
            if (silence)
                rx_done <= 1'b1;
            // Reply CRC recomputed over echo bytes before transmit
            if (state == S_CHECK)
                crc <= reply_crc(hdr[0], hdr[1], hdr[2], hdr[3], hdr[4], hdr[5]);
            if (state == S_CHECK)
                lrc <= hdr[0] + hdr[1] + hdr[2] + hdr[3] + hdr[4] + hdr[5];
        end
    end

    // Combinational reply CRC, same bit steps as the serial path
    function automatic logic [15:0] reply_crc(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                                             input logic [7:0] b3, input logic [7:0] b4, input logic [7:0] b5);
        logic [15:0] c;
        logic [7:0] bs [6];
        c = SFCM_CRC_INIT;
        bs[0] = b0;
        bs[1] = b1;
        bs[2] = b2;
        bs[3] = b3;
        bs[4] = b4;
        bs[5] = b5;
        for (int k = 0; k < 6; k++)
        begin
            c = c ^ {8'h00, bs[k]};
            for (int j = 0; j < SFCM_BITS_PER_BYTE; j++)
                c = c[0] ? ({1'b0, c[15:1]} ^ SFCM_CRC_POLY) : {1'b0, c[15:1]};
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Transmit sequencer
    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tx_item <= 4'd0;
            tx_phase <= 2'd0;
            tx_hex_lo <= 1'b0;
            tx_idx <= 3'd0;
            tx_cur <= 8'h00;
            TX_BYTE <= 8'h00;
            FRAME_OK <= 1'b0;
            FRAME_BAD <= 1'b0;
            WORD_DATA <= 16'h0000;
            WORD_ADDR <= 16'h0000;
            WORD_STROBE <= 1'b0;
        end
        else
        begin
            FRAME_OK <= (state == S_CHECK) && frame_good;
            FRAME_BAD <= (state == S_CHECK) && !frame_good;
            WORD_STROBE <= 1'b0;
            if (state == S_RX && take && byte_idx >= 8'(SFCM_HDR_BYTES) && !byte_idx[0]
                && byte_idx < 8'(SFCM_HDR_BYTES) + hdr[6])
            begin
                WORD_DATA <= {data_hi, in_b};
                WORD_ADDR <= {hdr[2], hdr[3]} + word_cnt;
                WORD_STROBE <= 1'b1;
            end
            if (state == S_CHECK && frame_good)
            begin
                tx_item <= 4'd0;
                tx_idx <= 3'd0;
                tx_hex_lo <= 1'b0;
                tx_phase <= 2'd0;
                TX_BYTE <= ASCII_MODE ? SFCM_ASCII_COLON : hdr[0];
            end
            else if (state == S_TX_BYTE && TX_READY)
            begin
                if (ASCII_MODE)
                begin
                    // Phase 0 start char, 1 hex chars, 2 CR, 3 LF
                    unique case (tx_phase)
                        2'd0:
                        begin
                            tx_phase <= 2'd1;
                            tx_cur <= tx_byte_now;
                            TX_BYTE <= hexc(tx_byte_now[7:4]);
                        end
                        2'd1:
                        begin
                            if (!tx_hex_lo)
                            begin
                                tx_hex_lo <= 1'b1;
                                TX_BYTE <= hexc(tx_cur[3:0]);
                            end
                            else if (!tx_last_item)
                            begin
                                tx_hex_lo <= 1'b0;
                                tx_item <= tx_item + 4'd1;
                                tx_idx <= tx_idx + 3'd1;
                                tx_cur <= next_b(tx_item + 4'd1);
                                TX_BYTE <= hexc(next_b(tx_item + 4'd1) >> 4);
                            end
                            else
                            begin
                                tx_phase <= 2'd2;
                                TX_BYTE <= SFCM_ASCII_CR;
                            end
                        end
                        2'd2:
                        begin
                            tx_phase <= 2'd3;
                            TX_BYTE <= SFCM_ASCII_LF;
                        end
                        2'd3: tx_phase <= 2'h3;
                    endcase
                end
                else if (!tx_last_item)
                begin
                    tx_item <= tx_item + 4'd1;
                    tx_idx <= tx_idx + 3'd1;
                    TX_BYTE <= next_b(tx_item + 4'd1);
                end
            end
        end
    end

    function automatic logic [7:0] hexc(input logic [7:0] v);
        return (v[3:0] < 4'hA) ? (SFCM_ASCII_ZERO + {4'h0, v[3:0]}) : (SFCM_ASCII_A_MINUS_10 + {4'h0, v[3:0]});
    endfunction

    function automatic logic [7:0] next_b(input logic [3:0] it);
        if (it < 4'(SFCM_REPLY_BYTES))
            return hdr[it[2:0]];
        else if (ASCII_MODE)
            return lrc_b;
        else if (it == 4'(SFCM_REPLY_BYTES))
            return crc_b[7:0];
        else
            return crc_b[15:8];
    endfunction
endmodule // sfcm_top

// ---- test/sfcm_host_model.sv ----
// Host master model: sends request bytes and paces reply acceptance
`timescale 1ns/1ps
module sfcm_host_model (
    input wire logic CLK_SYS,
    input wire logic RX_READY,
    output logic RX_VALID,
    output logic [7:0] RX_BYTE,
    output logic RX_END,
    output logic TX_READY
);
    logic slow = 1'b0;
    logic full_seen = 1'b0;
    logic toggle = 1'b0;
    initial
    begin
        RX_VALID = 1'b0;
        RX_BYTE = 8'h00;
        RX_END = 1'b0;
    end
    // Slow mode takes a reply byte only every other cycle
    always @(negedge CLK_SYS)
    begin
        toggle <= ~toggle;
        TX_READY <= ~slow | toggle;
    end
    task automatic send(input logic [7:0] f[$], input logic asc);
        int n;
        foreach (f[i])
        begin
            @(negedge CLK_SYS);
            RX_VALID = 1'b1;
            RX_BYTE = f[i];
            RX_END = asc && (i == f.size() - 1);
            n = 0;
            // Ready only moves at a rising edge, so the falling edge shows what the next rise takes
            while (RX_READY !== 1'b1 && n < 400)
            begin
                full_seen = 1'b1;
                n++;
                @(negedge CLK_SYS);
            end
            @(posedge CLK_SYS);
        end
        // Idle line shows the inverse so a stale byte cannot pass for data
        @(negedge CLK_SYS);
        RX_VALID = 1'b0;
        RX_BYTE = ~RX_BYTE;
        RX_END = 1'b0;
    endtask
endmodule // sfcm_host_model

// ---- test/sfcm_properties.sv ----
// Checker module: port-level properties of the frame checker and responder
`timescale 1ns/1ps
module sfcm_properties #(
    parameter logic [7:0] STATION = 8'h01
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic ASCII_MODE,
    input wire logic RX_VALID,
    input wire logic RX_READY,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic [7:0] TX_BYTE,
    input wire logic FRAME_OK,
    input wire logic FRAME_BAD
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_reply_start; $rose(TX_VALID); endsequence
    sequence s_rtu_take; RX_VALID && RX_READY && !ASCII_MODE; endsequence
    property p_one_verdict; !(FRAME_OK && FRAME_BAD); endproperty
    property p_ok_pulse; FRAME_OK |=> !FRAME_OK; endproperty
    property p_bad_pulse; FRAME_BAD |=> !FRAME_BAD; endproperty
    property p_tx_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE); endproperty
    property p_bad_silent; FRAME_BAD |-> !TX_VALID [*8]; endproperty
    property p_ok_replies; FRAME_OK |-> ##[0:100] TX_VALID; endproperty
    property p_ascii_start; s_reply_start ##0 ASCII_MODE |-> TX_BYTE == 8'h3A; endproperty
    property p_rtu_start; s_reply_start ##0 !ASCII_MODE |-> TX_BYTE == STATION; endproperty
    // Only uppercase hex digits and the framing characters may leave in ASCII mode
    property p_ascii_hex;
        ASCII_MODE && TX_VALID |-> TX_BYTE inside {[8'h30:8'h39], [8'h41:8'h46], 8'h3A, 8'h0D, 8'h0A};
    endproperty
    property p_rtu_silence; s_rtu_take |=> !FRAME_OK [*8]; endproperty
    ////////////////////////////////////////////////////////////////////////////
    a_one_verdict:
        assert property (p_one_verdict) else $error("both verdicts at once");
    a_ok_pulse:
        assert property (p_ok_pulse) else $error("good verdict longer than a cycle");
    a_bad_pulse:
        assert property (p_bad_pulse) else $error("bad verdict longer than a cycle");
    a_tx_hold:
        assert property (p_tx_hold) else $error("reply byte changed while stalled");
    a_bad_silent:
        assert property (p_bad_silent) else $error("reply after refused frame");
    a_ok_replies:
        assert property (p_ok_replies) else $error("no reply after good frame");
    a_ascii_start:
        assert property (p_ascii_start) else $error("ascii reply not opened by colon");
    a_rtu_start:
        assert property (p_rtu_start) else $error("rtu reply not opened by station");
    a_ascii_hex:
        assert property (p_ascii_hex) else $error("illegal ascii reply character");
    a_rtu_silence:
        assert property (p_rtu_silence) else $error("rtu frame judged before silence");
endmodule // sfcm_properties

// ---- test/tb_serial_frame_check_multiwrite.sv ----
// Self-checking bench for the write-multiple frame checker and responder
`timescale 1ns/1ps
`define CHK(w, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", w, e, g); end end
module tb_serial_frame_check_multiwrite;
    import sfcm_pkg::*;
    typedef logic [7:0] sfcm_bytes_t[$];
    localparam int SIL = 50;
    localparam logic [7:0] STATION = 8'h01;
    logic CLK_SYS = 1'b0;
    logic RESET_N = 1'b0;
    logic ASCII_MODE = 1'b0;
    logic RX_VALID, RX_READY, RX_END, TX_VALID, TX_READY, FRAME_OK, FRAME_BAD, WORD_STROBE;
    logic [7:0] RX_BYTE, TX_BYTE;
    logic [15:0] WORD_DATA, WORD_ADDR;
    int mismatches = 0;
    int checks = 0;
    int n_ok, n_bad, judge_wait;
    logic [7:0] tx_q[$];
    logic [31:0] word_q[$];
    sfcm_bytes_t hdr = {8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02};
    sfcm_bytes_t body = {8'h01, 8'h10, 8'h05, 8'h00, 8'h00, 8'h02, 8'h04, 8'h13, 8'h88, 8'h0F, 8'hA0};
    sfcm_top #(.SILENCE_CYCLES(SIL), .STATION(STATION)) uut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
        .ASCII_MODE(ASCII_MODE), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_BYTE(RX_BYTE), .RX_END(RX_END),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_BYTE(TX_BYTE), .FRAME_OK(FRAME_OK), .FRAME_BAD(FRAME_BAD),
        .WORD_DATA(WORD_DATA), .WORD_ADDR(WORD_ADDR), .WORD_STROBE(WORD_STROBE));
    sfcm_host_model host (.CLK_SYS(CLK_SYS), .RX_READY(RX_READY), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
        .RX_END(RX_END), .TX_READY(TX_READY));
    always #2.5 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS)
    begin
        if (TX_VALID === 1'b1 && TX_READY === 1'b1)
            tx_q.push_back(TX_BYTE);
        if (WORD_STROBE === 1'b1)
            word_q.push_back({WORD_ADDR, WORD_DATA});
        n_ok += (FRAME_OK === 1'b1);
        n_bad += (FRAME_BAD === 1'b1);
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic sfcm_bytes_t add_crc(sfcm_bytes_t b);
        logic [15:0] r;
        r = 16'hFFFF;
        foreach (b[i])
        begin
            r = r ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
        end
        return {b, r[7:0], r[15:8]};
    endfunction
    function automatic sfcm_bytes_t add_lrc(sfcm_bytes_t b);
        logic [7:0] s;
        s = 8'h00;
        foreach (b[i])
            s = s + b[i];
        return {b, 8'h00 - s};
    endfunction
    function automatic logic [7:0] hexc(logic [3:0] n);
        return (n < 4'hA) ? (8'h30 + n) : (8'h37 + n);
    endfunction
    function automatic sfcm_bytes_t to_ascii(sfcm_bytes_t b);
        sfcm_bytes_t a;
        a = {8'h3A};
        foreach (b[i])
            a = {a, hexc(b[i][7:4]), hexc(b[i][3:0])};
        return {a, 8'h0D, 8'h0A};
    endfunction
    task automatic cmp_q(string what, sfcm_bytes_t exp);
        `CHK(what, exp.size(), tx_q.size())
        foreach (exp[i])
            `CHK(what, exp[i], tx_q[i])
    endtask
    // Waits for the verdict, then for the whole reply, then watches for stray bytes
    task automatic run_frame(sfcm_bytes_t f, logic asc, logic slow, int exp_n);
        tx_q.delete();
        word_q.delete();
        n_ok = 0;
        n_bad = 0;
        judge_wait = 0;
        @(negedge CLK_SYS);
        ASCII_MODE = asc;
        host.slow = slow;
        host.full_seen = 1'b0;
        host.send(f, asc);
        while (n_ok + n_bad == 0 && judge_wait < 2000)
        begin
            @(negedge CLK_SYS);
            judge_wait++;
        end
        for (int i = 0; i < 2000 && tx_q.size() < exp_n; i++)
            @(negedge CLK_SYS);
        repeat (20) @(negedge CLK_SYS);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_rtu_write;
        run_frame(add_crc(body), 1'b0, 1'b1, 8);
        `CHK("rtu verdict", 1, n_ok)
        `CHK("rtu silence", 1'b1, judge_wait >= SIL - 1)
        `CHK("rx stalled", 1'b1, host.full_seen)
        `CHK("word count", 2, word_q.size())
        `CHK("first word", 32'h0500_1388, word_q[0])
        `CHK("second word", 32'h0501_0FA0, word_q[1])
        cmp_q("rtu reply", add_crc(hdr));
    endtask
    task automatic t_ascii_write;
        run_frame(add_lrc(body), 1'b1, 1'b1, 17);
        `CHK("ascii verdict", 1, n_ok)
        `CHK("ascii first word", 32'h0500_1388, word_q[0])
        `CHK("ascii word", 32'h0501_0FA0, word_q[1])
        cmp_q("ascii reply", to_ascii(add_lrc(hdr)));
    endtask
    task automatic t_refusals;
        sfcm_bytes_t f;
        int pos[3] = '{0, 1, 6};
        logic [7:0] val[3] = '{8'h02, 8'h03, 8'h03};
        for (int j = 0; j < 3; j++)
        begin
            f = body;
            f[pos[j]] = val[j];
            run_frame(add_crc(f), 1'b0, 1'b0, 0);
            `CHK("refused verdict", 1, n_bad)
            `CHK("refused reply", 0, tx_q.size())
        end
    endtask
    task automatic t_bad_check;
        sfcm_bytes_t f;
        f = add_lrc(body);
        f[11] = f[11] ^ 8'h01;
        run_frame(f, 1'b1, 1'b0, 0);
        `CHK("lrc refused", 1, n_bad)
        `CHK("lrc no reply", 0, tx_q.size())
        f = add_crc(body);
        f[12] = f[12] ^ 8'h80;
        run_frame(f, 1'b0, 1'b0, 0);
        `CHK("crc refused", 1, n_bad)
        `CHK("crc no reply", 0, tx_q.size())
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge CLK_SYS);
        RESET_N = 1'b1;
        t_rtu_write();
        t_ascii_write();
        t_refusals();
        t_bad_check();
        print_verdict();
    end
    // Seven frames need some 1000 cycles; this leaves ample margin
    initial
    begin
        #100us;
        mismatches++;
        print_verdict();
    end
endmodule // tb_serial_frame_check_multiwrite
bind sfcm_top sfcm_properties #(.STATION(STATION)) u_props (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .ASCII_MODE(ASCII_MODE), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_BYTE(TX_BYTE), .FRAME_OK(FRAME_OK), .FRAME_BAD(FRAME_BAD));
